/* src/sbc_control.sv */
// Control and write-enable decoding of a synchronous burst memory
`timescale 1ns/1ns
`include "sbc_consts.svh"
module sbc_control (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic reset_i,
  // Synchronous control pins
  input wire sbc_pkg::sbc_ctl_t ctl_i,
  input wire logic [1:0] lane_write_inputs_n_i,
  input wire logic [16:0] word_address_bus_i,
  // Asynchronous and static pins
  input wire logic output_enable_n_i,
  input wire logic burst_order_select_n_i,
  input wire logic flow_through_select_n_i,
  input wire logic sleep_request_i,
  // Data pins split into input, output and enable
  input wire logic [17:0] dq_i,
  output logic [17:0] dq_o,
  output logic dq_oe_o,
  // Storage array side
  output logic [16:0] mem_rd_addr_o,
  output logic mem_rd_en_o,
  input wire logic [17:0] mem_rdata_i,
  output sbc_pkg::sbc_wr_t mem_wr_o,
  // Status
  output logic selected_o,
  output logic sleeping_o
);
  // Access state
  // Sleep is a state of its own so its status pin is registered
  sbc_pkg::sbc_state_t state;
  sbc_pkg::sbc_state_t next_state;
  // Registered base address and burst step
  logic [16:0] addr;
  logic [16:0] next_addr;
  logic [1:0] count;
  logic [1:0] next_count;
  // Read pending on the registered address
  logic rd_pend;
  logic next_rd_pend;
  // Output register and its valid flag
  logic [17:0] out_data;
  logic [17:0] next_out_data;
  logic out_valid;
  logic next_out_valid;
  // Write request register towards the array
  sbc_pkg::sbc_wr_t wr;
  sbc_pkg::sbc_wr_t next_wr;
  // Write seen on the last edge blocks the drivers
  logic wr_seen;
  logic next_wr_seen;

  // Decoded strobes and selects
  logic p_strobe;
  logic c_strobe;
  logic all_sel;
  logic p_start;
  logic c_start;
  logic start;
  logic advance;
  // Write decode results
  logic [1:0] lane_we;
  logic is_write;
  logic [1:0] addr_lo;
  logic [16:0] cur_addr;
  // Low bits one burst step ahead, used by writes that advance
  logic [1:0] addr_lo_step;

  // Per-lane write enables
  // Lane decode is purely combinational; the write register sits here
  sbc_write_decode u_we (
    .all_bytes_write_n_i(ctl_i.all_bytes_write_n),
    .byte_write_gate_n_i(ctl_i.byte_write_gate_n),
    .lane_write_inputs_n_i(lane_write_inputs_n_i),
    .lane_we_o(lane_we),
    .is_write_o(is_write)
  );

  // Burst low bits from base and step
  // Sequencer only maps the step to low bits; the count lives here
  sbc_burst_seq u_seq (
    .base_i(addr[1:0]),
    .count_i(count),
    .burst_order_select_n_i(burst_order_select_n_i),
    .addr_lo_o(addr_lo)
  );

  // Address currently being accessed
  // Upper bits never change within a burst
  assign cur_addr = {addr[16:2], addr_lo};

  // Strobe qualification
  always_comb begin
    // Pin levels turned into active-high strobes
    p_strobe = !ctl_i.processor_addr_strobe_n;
    c_strobe = !ctl_i.controller_addr_strobe_n;
    // Master select gates the processor strobe only
    p_start = p_strobe && !ctl_i.master_select_n;
    // Controller start counts only with processor strobe high
    // A blocked processor strobe counts as high; with both strobes
    // low and master select on, the processor start wins
    c_start = c_strobe && !p_start;
    start = p_start || c_start;
    // Secondaries only matter on a qualifying strobe edge
    all_sel = !ctl_i.master_select_n && ctl_i.secondary_select_high &&
      !ctl_i.secondary_select_low_n;
    // Advance only without a processor start or a controller strobe, which covers the start edge
    // A blocked processor strobe must not stall an ongoing burst
    advance = !ctl_i.burst_advance_n && !p_start && !c_strobe;
  end

  // Next-state logic for control and write groups, evaluated every edge
  // Priority: sleep, then a strobe start, then burst continue or suspend.
  // Sleep is level-sensitive, so a burst caught by it must be restarted.
  always_comb begin
    next_state = state;
    next_addr = addr;
    next_count = count;
    // Read pending lasts a single edge unless renewed
    next_rd_pend = 1'b0;
    next_wr = wr;
    // Lane pulse and write flag drop unless this edge writes
    next_wr.lanes = `SBC_LANE_RST;
    next_wr_seen = 1'b0;
    if (sleep_request_i) begin
      // Sync pins ignored; array contents stay put
      // Sleep wins over any strobe on the same edge
      next_state = sbc_pkg::SBC_SLEEP;
    end else begin
      case (state)
        sbc_pkg::SBC_IDLE, sbc_pkg::SBC_BURST, sbc_pkg::SBC_SLEEP: begin
          if (start && all_sel) begin
            // New external address on a selected strobe edge
            next_state = sbc_pkg::SBC_BURST;
            next_addr = word_address_bus_i;
            // Fresh burst starts at step zero
            next_count = `SBC_CNT_RST;
            if (c_start && is_write) begin
              // Controller start samples write enables here
              next_wr.lanes = lane_we;
              next_wr.addr = word_address_bus_i;
              next_wr.data = dq_i;
              next_wr_seen = 1'b1;
            end else begin
              // Processor start is always a read
              next_rd_pend = 1'b1;
            end
          end else if (start) begin
            // Strobe without full select deselects in one cycle
            next_state = sbc_pkg::SBC_IDLE;
          end else if (state == sbc_pkg::SBC_BURST) begin
            // Continue or suspend the burst on strobe-free edges
            if (advance) begin
              next_count = 2'(count + 2'h1);
            end
            // Later edges sample the write pins afresh
            if (is_write) begin
              // Write at the address this edge points to
              next_wr.lanes = lane_we;
              // Advance on a write edge targets the next word
              next_wr.addr = advance ? {addr[16:2], 2'(addr_lo_step)} : cur_addr;
              next_wr.data = dq_i;
              next_wr_seen = 1'b1;
            end else begin
              // No lane written: this edge reads
              next_rd_pend = 1'b1;
            end
          end else begin
            // Leaving sleep without a strobe returns to idle
            next_state = sbc_pkg::SBC_IDLE;
          end
        end
        default: begin
          // Unused state code recovers to idle
          next_state = sbc_pkg::SBC_IDLE;
        end
      endcase
    end
  end

  // Low bits of the address one step ahead, for writes that advance
  // Same two orders as the sequencer, one count further on
  always_comb begin
    if (burst_order_select_n_i) begin
      addr_lo_step = addr[1:0] ^ 2'(count + 2'h1);
    end else begin
      addr_lo_step = 2'(addr[1:0] + count + 2'h1);
    end
  end

  // Output register group: loads every edge, valid only after a read
  always_comb begin
    // Array data one edge late gives the pipelined timing
    next_out_data = mem_rdata_i;
    next_out_valid = rd_pend && (state == sbc_pkg::SBC_BURST);
    if (sleep_request_i) begin
      // No read data survives into sleep
      next_out_valid = 1'b0;
    end
  end

  // Control group registers, all sampled on the one clock
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      // Idle, nothing pending, burst step at zero
      state <= sbc_pkg::SBC_IDLE;
      addr <= `SBC_ADDR_RST;
      count <= `SBC_CNT_RST;
      rd_pend <= 1'b0;
    end else begin
      // Every synchronous pin acts through these registers
      state <= next_state;
      addr <= next_addr;
      count <= next_count;
      rd_pend <= next_rd_pend;
    end
  end

  // Write group registers; lanes form a one-cycle pulse
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      // No write may leak out of reset
      wr <= '0;
      wr_seen <= 1'b0;
    end else begin
      // Pulse lasts exactly one cycle
      wr <= next_wr;
      wr_seen <= next_wr_seen;
    end
  end

  // Output group registers; zero data keeps the pins quiet after reset in pipelined mode, since flow-through shows the array
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      out_data <= `SBC_DATA_RST;
      out_valid <= 1'b0;
    end else begin
      // Reloaded every edge; the valid flag qualifies it
      out_data <= next_out_data;
      out_valid <= next_out_valid;
    end
  end

  // Array read port follows the burst address
  // Read enable drops at once with sleep, before the state catches up
  assign mem_rd_addr_o = cur_addr;
  assign mem_rd_en_o = rd_pend && (state == sbc_pkg::SBC_BURST) && !sleep_request_i;
  assign mem_wr_o = wr;

  // Data pins: flow-through bypasses the output register
  // Flow-through trades a cycle of latency for a longer clock-to-data path
  always_comb begin
    if (!flow_through_select_n_i) begin
      // Straight from the array
      dq_o = mem_rdata_i;
    end else begin
      // From the output register
      dq_o = out_data;
    end
  end

  // Drivers on only for an enabled read with output enable low
  // A write sampled on the last edge wins over output enable, so the
  // bus master never contends with the pins while it presents write data
  always_comb begin
    dq_oe_o = 1'b0;
    if (!output_enable_n_i && !sleep_request_i && !wr_seen) begin
      if (flow_through_select_n_i) begin
        // Pipelined: once the output register holds read data
        dq_oe_o = out_valid;
      end else begin
        // Flow-through: as soon as the array read is valid
        dq_oe_o = mem_rd_en_o;
      end
    end
  end

  // Status pins
  // Both come straight from the state register
  assign selected_o = (state == sbc_pkg::SBC_BURST);
  assign sleeping_o = (state == sbc_pkg::SBC_SLEEP);
endmodule

/* pkg/sbc_consts.svh */
// Width and reset constants for the burst memory control decoder
`ifndef SBC_CONSTS_SVH
`define SBC_CONSTS_SVH
`define SBC_ADDR_W 17
`define SBC_DATA_W 18
`define SBC_LANE_W 9
`define SBC_LANES 2
`define SBC_BURST_W 2
`define SBC_ADDR_RST 17'h00000
`define SBC_DATA_RST 18'h00000
`define SBC_LANE_RST 2'h0
`define SBC_CNT_RST 2'h0
`endif

/* pkg/sbc_pkg.sv */
// Types shared by the burst memory control decoder files
package sbc_pkg;
  // Synchronous control pins, all active low except secondary_select_high
  typedef struct packed {
    logic processor_addr_strobe_n;
    logic controller_addr_strobe_n;
    logic burst_advance_n;
    logic master_select_n;
    logic secondary_select_high;
    logic secondary_select_low_n;
    logic all_bytes_write_n;
    logic byte_write_gate_n;
  } sbc_ctl_t;

  // Write request towards the storage array
  typedef struct packed {
    logic [1:0] lanes;
    logic [16:0] addr;
    logic [17:0] data;
  } sbc_wr_t;

  // Access state
  typedef enum logic [1:0] {SBC_IDLE, SBC_BURST, SBC_SLEEP} sbc_state_t;
endpackage

/* src/sbc_write_decode.sv */
// Per-lane internal write decode
`timescale 1ns/1ns
`include "sbc_consts.svh"
module sbc_write_decode (
  // Write pins
  input wire logic all_bytes_write_n_i,
  input wire logic byte_write_gate_n_i,
  input wire logic [1:0] lane_write_inputs_n_i,
  // Decoded result
  output logic [1:0] lane_we_o,
  output logic is_write_o
);
  genvar g;
  // One decode per lane
  generate
    for (g = 0; g < `SBC_LANES; g = g + 1) begin : g_lane
      // Global write forces every lane; else gate and lane pin both low
      assign lane_we_o[g] = !all_bytes_write_n_i ||
        (!byte_write_gate_n_i && !lane_write_inputs_n_i[g]);
    end
  endgenerate
  // Any lane written makes a write, none makes a read
  assign is_write_o = |lane_we_o;
endmodule

/* src/sbc_burst_seq.sv */
// Burst address low bits for interleaved or linear order
`timescale 1ns/1ns
`include "sbc_consts.svh"
module sbc_burst_seq (
  // Start offset and step count
  input wire logic [1:0] base_i,
  input wire logic [1:0] count_i,
  // Order select, high or open means interleaved
  input wire logic burst_order_select_n_i,
  // Resulting low address bits
  output logic [1:0] addr_lo_o
);
  // Exclusive-or order versus wrapping add
  always_comb begin
    if (burst_order_select_n_i) begin
      addr_lo_o = base_i ^ count_i;
    end else begin
      addr_lo_o = 2'(base_i + count_i);
    end
  end
endmodule

/* tb/sbc_control_checker.sv */
// Port-level assertions for the burst memory control decoder
`timescale 1ns/1ns
module sbc_control_checker (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic reset_i,
  // Watched inputs
  input wire sbc_pkg::sbc_ctl_t ctl_i,
  input wire logic [1:0] lane_write_inputs_n_i,
  input wire logic [16:0] word_address_bus_i,
  input wire logic output_enable_n_i,
  input wire logic sleep_request_i,
  // Watched outputs
  input wire logic dq_oe_o,
  input wire logic [16:0] mem_rd_addr_o,
  input wire logic mem_rd_en_o,
  input wire sbc_pkg::sbc_wr_t mem_wr_o,
  input wire logic selected_o,
  input wire logic sleeping_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (reset_i);
  // Start decodes; sleep excluded since it freezes the pins
  logic awake, sel, p_go, c_go;
  logic [1:0] exp_ln;
  assign awake = !sleep_request_i && !sleeping_o;
  assign sel = !ctl_i.master_select_n && ctl_i.secondary_select_high
    && !ctl_i.secondary_select_low_n;
  assign p_go = awake && !ctl_i.processor_addr_strobe_n && !ctl_i.master_select_n;
  assign c_go = awake && !ctl_i.controller_addr_strobe_n && ctl_i.processor_addr_strobe_n;
  // Lanes expected with the all-bytes input high
  assign exp_ln = ctl_i.byte_write_gate_n ? 2'h0 : ~lane_write_inputs_n_i;
  a_all_bytes: assert property (c_go && sel && !ctl_i.all_bytes_write_n
    |=> mem_wr_o.lanes == 2'h3) else $error("all-bytes write missed a lane");
  a_lane_gate: assert property (c_go && sel && ctl_i.all_bytes_write_n
    |=> mem_wr_o.lanes == $past(exp_ln)) else $error("lane write decode wrong");
  a_addr_load: assert property (p_go && sel
    |=> mem_rd_addr_o == $past(word_address_bus_i)) else $error("address not loaded");
  a_proc_read: assert property (p_go && sel
    |=> selected_o && mem_rd_en_o && mem_wr_o.lanes == 2'h0) else $error("read not begun");
  a_master_block: assert property (awake && ctl_i.master_select_n && selected_o
    && !ctl_i.processor_addr_strobe_n && ctl_i.controller_addr_strobe_n
    |=> selected_o) else $error("blocked strobe ended the burst");
  a_desel_ctrl: assert property (c_go && !sel
    |=> !selected_o && mem_wr_o.lanes == 2'h0) else $error("deselect failed");
  a_oe_off: assert property (output_enable_n_i |-> !dq_oe_o)
    else $error("driving with output enable off");
  a_write_quiet: assert property (mem_wr_o.lanes != 2'h0 |-> !dq_oe_o)
    else $error("driving during write");
  a_sleep_in: assert property (sleep_request_i
    |=> sleeping_o && mem_wr_o.lanes == 2'h0) else $error("sleep not entered");
  // Main scenarios reached
  c_read: cover property (p_go && sel);
  c_write: cover property (c_go && sel && !ctl_i.all_bytes_write_n);
  c_sleep: cover property (sleeping_o);
endmodule
bind sbc_control sbc_control_checker u_chk (.clk_sys_i(clk_sys_i), .reset_i(reset_i),
  .ctl_i(ctl_i), .lane_write_inputs_n_i(lane_write_inputs_n_i),
  .word_address_bus_i(word_address_bus_i), .output_enable_n_i(output_enable_n_i),
  .sleep_request_i(sleep_request_i), .dq_oe_o(dq_oe_o), .mem_rd_addr_o(mem_rd_addr_o),
  .mem_rd_en_o(mem_rd_en_o), .mem_wr_o(mem_wr_o), .selected_o(selected_o),
  .sleeping_o(sleeping_o));

/* tb/sbc_array_model.sv */
// Storage array stand-in answering reads from the address
`timescale 1ns/1ns
module sbc_array_model (
  // Read request
  input wire logic [16:0] rd_addr_i,
  input wire logic rd_en_i,
  // Read answer
  output logic [17:0] rdata_o
);
  // Inverted pattern when idle, so stale data never looks valid
  assign rdata_o = rd_en_i ? {1'b1, rd_addr_i} : ~{1'b1, rd_addr_i};
endmodule

/* tb/tb_top.sv */
// Self-checking bench for the burst memory control decoder
`timescale 1ns/1ns
module tb_top;
  logic clk_sys_i = 1'b0;
  logic reset_i = 1'b1;
  sbc_pkg::sbc_ctl_t ctl, c;
  // Idle: strobes and advance high, selects active, writes off
  sbc_pkg::sbc_ctl_t idle = 8'hEB;
  logic [1:0] ln_n = 2'h3, e;
  logic [16:0] addr = 17'h00000, a, rd_addr;
  logic oe_n = 1'b1, lbo_n = 1'b1, ft_n = 1'b1, zz = 1'b0;
  logic [17:0] dq_tb = 18'h00000, d, dq_i, dq_o, rdata;
  logic dq_oe_o, rd_en, sel_o, slp_o;
  sbc_pkg::sbc_wr_t wr, exp_wr;
  sbc_pkg::sbc_wr_t wq[$];
  int fail_count = 0, n_compared = 0;
  always #2 clk_sys_i = ~clk_sys_i;
  // Shared data wire: decoder drives when enabled, bench otherwise
  assign dq_i = dq_oe_o ? dq_o : dq_tb;
  sbc_control DUT (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .ctl_i(ctl),
    .lane_write_inputs_n_i(ln_n), .word_address_bus_i(addr), .output_enable_n_i(oe_n),
    .burst_order_select_n_i(lbo_n), .flow_through_select_n_i(ft_n), .sleep_request_i(zz),
    .dq_i(dq_i), .dq_o(dq_o), .dq_oe_o(dq_oe_o), .mem_rd_addr_o(rd_addr),
    .mem_rd_en_o(rd_en), .mem_rdata_i(rdata), .mem_wr_o(wr), .selected_o(sel_o),
    .sleeping_o(slp_o));
  sbc_array_model u_arr (.rd_addr_i(rd_addr), .rd_en_i(rd_en), .rdata_o(rdata));
  task automatic chk(input string nm, input logic [36:0] seen, input logic [36:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic complete_run;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // Each write pulse takes the oldest expected write
  always @(posedge clk_sys_i) begin
    if (!reset_i && wr.lanes !== 2'h0) begin
      exp_wr = wq.size() ? wq.pop_front() : '0;
      chk("write", wr, exp_wr);
    end
  end
  // Watchdog far beyond the roughly fifty cycles needed
  initial begin
    repeat (2000) @(posedge clk_sys_i);
    fail_count++;
    complete_run;
  end
  initial begin
    ctl = idle;
    void'($urandom(32'h83f82c29));
    repeat (4) @(posedge clk_sys_i);
    reset_i <= 1'b0;
    // Every write-pin code, back to back, via controller strobe
    for (int i = 0; i < 16; i++) begin
      @(posedge clk_sys_i);
      a = 17'($urandom);
      d = 18'($urandom);
      c = idle;
      c.controller_addr_strobe_n = 1'b0;
      c.all_bytes_write_n = i[3];
      c.byte_write_gate_n = i[2];
      e = !i[3] ? 2'h3 : (i[2] ? 2'h0 : ~i[1:0]);
      if (e != 2'h0) wq.push_back({e, a, d});
      ctl <= c;
      ln_n <= i[1:0];
      addr <= a;
      dq_tb <= d;
    end
    @(posedge clk_sys_i);
    ctl <= idle;
    $display("write codes done");
    // Reads in each order and output mode, then a burst step
    for (int m = 0; m < 4; m++) begin
      @(posedge clk_sys_i);
      ctl <= idle;
      oe_n <= 1'b0;
      ft_n <= m[1];
      lbo_n <= m[0];
      @(posedge clk_sys_i);
      a = {15'($urandom), 2'h1};
      c = idle;
      c.processor_addr_strobe_n = 1'b0;
      c.burst_advance_n = 1'b0;
      ctl <= c;
      addr <= a;
      @(posedge clk_sys_i);
      c = idle;
      c.burst_advance_n = 1'b0;
      ctl <= c;
      #1 chk("read address", rd_addr, a);
      chk("selected", sel_o, 1'b1);
      if (!m[1]) chk("flow data", dq_o, {1'b1, a});
      @(posedge clk_sys_i);
      #1 chk("burst step", rd_addr[1:0], m[0] ? 2'h0 : 2'h2);
      if (m[1]) chk("piped data", dq_o, {1'b1, a});
      chk("drive on", dq_oe_o, 1'b1);
      @(posedge clk_sys_i);
      oe_n <= 1'b1;
      ctl <= idle;
      #1 chk("drive off", dq_oe_o, 1'b0);
    end
    $display("read modes done");
    // Blocked processor strobe inside the burst, then deselect by controller strobe
    @(posedge clk_sys_i);
    c = idle;
    c.master_select_n = 1'b1;
    c.processor_addr_strobe_n = 1'b0;
    c.burst_advance_n = 1'b0;
    ctl <= c;
    @(posedge clk_sys_i);
    c = idle;
    c.controller_addr_strobe_n = 1'b0;
    c.secondary_select_high = 1'b0;
    ctl <= c;
    // Interleaved from offset 1 runs 1, 0, 3, 2: fourth word expected
    #1 chk("blocked", sel_o, 1'b1);
    chk("blocked step", rd_addr[1:0], 2'h2);
    @(posedge clk_sys_i);
    ctl <= idle;
    #1 chk("deselect", sel_o, 1'b0);
    $display("select tests done");
    // Sleep refuses a write attempt and ends on release
    @(posedge clk_sys_i);
    zz <= 1'b1;
    c = idle;
    c.controller_addr_strobe_n = 1'b0;
    c.all_bytes_write_n = 1'b0;
    ctl <= c;
    repeat (2) @(posedge clk_sys_i);
    #1 chk("sleeping", slp_o, 1'b1);
    @(posedge clk_sys_i);
    zz <= 1'b0;
    ctl <= idle;
    repeat (2) @(posedge clk_sys_i);
    #1 chk("awake", slp_o, 1'b0);
    chk("leftover writes", 37'(wq.size()), 37'h0);
    $display("sleep test done");
    complete_run;
  end
endmodule
